// file: src/scp_device.sv
`timescale 1ns/1ps
// Functional notes
// - select low enables configuration port
// - select high: port silent, position readout
// - host clock between 10 kHz and 1 MHz
// - read: code 10, address, eight data clocks
// - device shifts on fall, host samples rise
// - write: code 01, address, data, MSB first
// - idle clock and data held high
// - clock high whenever select changes
// - clock high 300 ns between commands
// - host reads back written registers
// - key AB at 0x10 unlocks registers
// - key A1 at 0x11 burns 0x00-0x01
// - key A2 at 0x12 burns 0x02-0x03
// - key A3 at 0x13 burns 0x04-0x06
// - key A4 at 0x14 burns supply setting
// - key A5 at 0x1B burns calibration
// - nonvolatile only through matching key
// - power-up reloads registers from OTP
module scp_device
   import scp_pkg::*;
#(
   parameter int NREG = 64
) (
   input wire logic sck,
   input wire logic nrst,
   scp_if.dev link,
   output logic [7:0] burn_pulse_count,
   output logic unlocked,
   output logic [NREG*8-1:0] reg_image
);
   logic [7:0] regs_r [NREG];
   logic [7:0] otp_r [NREG];
   logic [14:0] shift_r;
   logic [4:0] cnt_r;
   logic [7:0] rd_r;
   logic rd_act_r;
   logic unlock_r;
   logic boot_r;
   logic [7:0] burn_cnt_r;
   logic active;
   logic [15:0] frame;
   logic frame_done;
   logic [5:0] waddr;
   logic [7:0] wdata;
   logic is_write;
   logic wr_ok;
   logic [5:0] raddr;
   logic [5:0] raddr_hold;
   logic [7:0] rd_first;
   logic oe_r;

   // fixed-open addresses per unlock table
   function automatic logic never_locked(input logic [5:0] a);
      never_locked = (a <= 6'h03) || (a == SCP_ADDR_UNLOCK) || (a == SCP_ADDR_BURN_RSV)
         || (a == SCP_ADDR_BURN_ZERO) || (a == SCP_ADDR_BURN_CAL);
   endfunction

   // which burn command covers address a, given key write at command address c
   function automatic logic burn_covers(input logic [5:0] c, input logic [7:0] k,
                                        input logic [5:0] a);
      burn_covers = ((c == SCP_ADDR_BURN_RSV) && (k == SCP_KEY_RSV) && (a <= 6'h01))
         || ((c == SCP_ADDR_BURN_ZERO) && (k == SCP_KEY_ZERO) && (a >= 6'h02) && (a <= 6'h03))
         || ((c == SCP_ADDR_BURN_CFG) && (k == SCP_KEY_CFG) && (a >= 6'h04) && (a <= 6'h06))
         || ((c == SCP_ADDR_BURN_SUPPLY) && (k == SCP_KEY_SUPPLY) && (a == SCP_ADDR_SUPPLY))
         || ((c == SCP_ADDR_BURN_CAL) && (k == SCP_KEY_CAL) && (a == SCP_ADDR_CAL));
   endfunction

   assign active = !link.protocol_select;
   assign frame = {shift_r, link.shared_latch_or_datain_pin};
   assign frame_done = active && (cnt_r == 5'(SCP_FRAME_BITS - 1));
   assign waddr = frame[13:8];
   assign wdata = frame[7:0];
   assign is_write = frame_done && (frame[15:14] == SCP_OP_WRITE);
   assign wr_ok = is_write && (unlock_r || never_locked(waddr));
   assign raddr = frame[5:0];

   // bit counter and shift register; the link clock only runs inside frames
   always_ff @(posedge sck or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
         shift_r <= '0;
      end else if (!active) begin
         cnt_r <= '0;
      end else begin
         shift_r <= frame[14:0];
         cnt_r <= frame_done ? 5'h00 : cnt_r + 5'h01;
      end
   end

   // read command seen after eight bits: load data for the next eight clocks
   always_ff @(posedge sck or negedge nrst) begin
      if (!nrst) begin
         rd_act_r <= 1'b0;
      end else if (!active || frame_done) begin
         rd_act_r <= 1'b0;
      end else if (cnt_r == 5'(SCP_CMD_BITS - 1)) begin
         rd_act_r <= (frame[7:6] == SCP_OP_READ);
      end
   end

   // output shifts after falling edge so host samples stable on rise
   always_ff @(negedge sck or negedge nrst) begin
      if (!nrst) begin
         rd_r <= 8'hFF;
      end else if (cnt_r == 5'(SCP_CMD_BITS) && rd_act_r) begin
         rd_r <= {regs_r[raddr_hold][6:0], 1'b1};
      end else begin
         rd_r <= {rd_r[6:0], 1'b1};
      end
   end

   // address latched once the command byte is in
   always_ff @(posedge sck or negedge nrst) begin
      if (!nrst) begin
         raddr_hold <= '0;
      end else if (active && cnt_r == 5'(SCP_CMD_BITS - 1)) begin
         raddr_hold <= raddr;
      end
   end
   assign rd_first = regs_r[raddr_hold];

   // first data bit appears at the falling edge after the address bit
   always_ff @(negedge sck or negedge nrst) begin
      if (!nrst) begin
         link.shared_dataout_pin <= 1'b1;
         oe_r <= 1'b0;
      end else if (cnt_r == 5'(SCP_CMD_BITS) && rd_act_r) begin
         link.shared_dataout_pin <= rd_first[7];
         oe_r <= 1'b1;
      end else if (rd_act_r && active) begin
         link.shared_dataout_pin <= rd_r[7];
         oe_r <= 1'b1;
      end else begin
         link.shared_dataout_pin <= 1'b1;
         oe_r <= 1'b0;
      end
   end

   // no falling edge follows a frame, so gate the enable; select high frees the pin at once
   assign link.dataout_oe = oe_r && rd_act_r && active;

   // register file, unlock, burn and power-up reload
   always_ff @(posedge sck or negedge nrst) begin
      if (!nrst) begin
         unlock_r <= 1'b0;
         boot_r <= 1'b1;
         burn_cnt_r <= '0;
         for (int i = 0; i < NREG; i++) begin
            regs_r[i] <= SCP_REG_RESET;
         end
      end else if (boot_r) begin
         boot_r <= 1'b0;
         for (int i = 0; i < NREG; i++) begin
            regs_r[i] <= otp_r[i];
         end
      end else if (wr_ok) begin
         if (waddr == SCP_ADDR_UNLOCK) begin
            unlock_r <= (wdata == SCP_KEY_UNLOCK);
         end
         if (waddr >= SCP_ADDR_BURN_RSV && waddr <= SCP_ADDR_BURN_CAL
             && burn_covers(waddr, wdata, SCP_ADDR_SUPPLY) | burn_covers(waddr, wdata, 6'h00)
             | burn_covers(waddr, wdata, 6'h02) | burn_covers(waddr, wdata, 6'h04)
             | burn_covers(waddr, wdata, SCP_ADDR_CAL)) begin
            burn_cnt_r <= burn_cnt_r + 8'h01;
         end
         if (waddr < SCP_ADDR_UNLOCK || waddr > SCP_ADDR_BURN_CAL) begin
            regs_r[waddr] <= wdata;
         end else if (waddr > SCP_ADDR_BURN_SUPPLY && waddr < SCP_ADDR_BURN_CAL) begin
            regs_r[waddr] <= wdata;
         end
      end
   end

   // otp array: no reset, models fuses kept across power cycles
   always_ff @(posedge sck) begin
      for (int i = 0; i < NREG; i++) begin
         if (wr_ok && burn_covers(waddr, wdata, 6'(i))) begin
            otp_r[i] <= regs_r[i];
         end
      end
   end

   assign burn_pulse_count = burn_cnt_r;
   assign unlocked = unlock_r;
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_img
         assign reg_image[g*8 +: 8] = regs_r[g];
      end
   endgenerate
endmodule

// file: src/scp_host.sv
`timescale 1ns/1ps
module scp_host
   import scp_pkg::*;
#(
   parameter int HALF = SCP_HALF_CYC,
   parameter int GAP = SCP_GAP_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   scp_if.host link,
   input wire logic req,
   input wire logic req_write,
   input wire logic [5:0] req_addr,
   input wire logic [7:0] req_data,
   input wire logic cfg_mode,
   output logic busy,
   output logic done,
   output logic [7:0] rd_data
);
   scp_hstate_t st_r;
   logic [15:0] tx_r;
   logic [7:0] rx_r;
   logic [4:0] bit_r;
   logic [15:0] tmr_r;
   logic wr_r;
   logic sck_r;
   logic sel_r;
   logic do_s;
   logic tick;

   scp_sync #(.W(1)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .d(link.shared_dataout_pin),
      .q(do_s)
   );

   assign tick = (tmr_r == 16'(HALF - 1));

   // divider makes the link clock; edges only at half-period ticks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= SCP_H_IDLE;
         tx_r <= 16'hFFFF;
         rx_r <= '0;
         bit_r <= '0;
         tmr_r <= '0;
         wr_r <= 1'b0;
         sck_r <= 1'b1;
         sel_r <= 1'b1;
         busy <= 1'b0;
         done <= 1'b0;
         rd_data <= '0;
      end else begin
         done <= 1'b0;
         case (st_r)
            SCP_H_IDLE: begin
               sck_r <= 1'b1;
               tx_r <= 16'hFFFF;
               sel_r <= !cfg_mode;
               if (req && cfg_mode && !sel_r) begin
                  tx_r <= {req_write ? SCP_OP_WRITE : SCP_OP_READ, req_addr, req_data};
                  wr_r <= req_write;
                  bit_r <= '0;
                  tmr_r <= '0;
                  busy <= 1'b1;
                  st_r <= SCP_H_SHIFT;
               end
            end
            SCP_H_SHIFT: begin
               tmr_r <= tick ? 16'h0000 : tmr_r + 16'h0001;
               if (tick) begin
                  if (sck_r) begin
                     sck_r <= 1'b0; // data changes on fall
                     // first bit already stands; shifting on rise would race the device
                     if (bit_r != 5'h00) begin
                        tx_r <= {tx_r[14:0], 1'b1};
                     end
                  end else begin
                     sck_r <= 1'b1;
                     if (bit_r >= 5'(SCP_CMD_BITS)) begin
                        rx_r <= {rx_r[6:0], do_s};
                     end
                     bit_r <= bit_r + 5'h01;
                     if (bit_r == 5'(SCP_FRAME_BITS - 1)) begin
                        st_r <= SCP_H_GAP;
                        tmr_r <= '0;
                     end
                  end
               end
            end
            SCP_H_GAP: begin
               tmr_r <= tmr_r + 16'h0001;
               tx_r <= 16'hFFFF;
               if (tmr_r == 16'(GAP - 1)) begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  if (!wr_r) begin
                     rd_data <= rx_r;
                  end
                  st_r <= SCP_H_IDLE;
               end
            end
            default: st_r <= SCP_H_IDLE;
         endcase
      end
   end

   assign link.shared_serial_clock_pin = sck_r;
   assign link.shared_latch_or_datain_pin = tx_r[15];
   assign link.protocol_select = sel_r;
endmodule

// file: src/scp_if.sv
`timescale 1ns/1ps
interface scp_if;
   logic protocol_select;
   logic shared_serial_clock_pin;
   logic shared_latch_or_datain_pin;
   logic shared_dataout_pin;
   logic dataout_oe;
   modport dev (
      input protocol_select,
      input shared_serial_clock_pin,
      input shared_latch_or_datain_pin,
      output shared_dataout_pin,
      output dataout_oe
   );
   modport host (
      output protocol_select,
      output shared_serial_clock_pin,
      output shared_latch_or_datain_pin,
      input shared_dataout_pin,
      input dataout_oe
   );
endinterface

// file: src/scp_pkg.sv
package scp_pkg;
   localparam logic [1:0] SCP_OP_READ = 2'h2;
   localparam logic [1:0] SCP_OP_WRITE = 2'h1;
   localparam logic [5:0] SCP_ADDR_UNLOCK = 6'h10;
   localparam logic [5:0] SCP_ADDR_BURN_RSV = 6'h11;
   localparam logic [5:0] SCP_ADDR_BURN_ZERO = 6'h12;
   localparam logic [5:0] SCP_ADDR_BURN_CFG = 6'h13;
   localparam logic [5:0] SCP_ADDR_BURN_SUPPLY = 6'h14;
   localparam logic [5:0] SCP_ADDR_BURN_CAL = 6'h1B;
   localparam logic [5:0] SCP_ADDR_SUPPLY = 6'h15;
   localparam logic [5:0] SCP_ADDR_CAL = 6'h17;
   localparam logic [7:0] SCP_KEY_UNLOCK = 8'hAB;
   localparam logic [7:0] SCP_KEY_RSV = 8'hA1;
   localparam logic [7:0] SCP_KEY_ZERO = 8'hA2;
   localparam logic [7:0] SCP_KEY_CFG = 8'hA3;
   localparam logic [7:0] SCP_KEY_SUPPLY = 8'hA4;
   localparam logic [7:0] SCP_KEY_CAL = 8'hA5;
   localparam logic [7:0] SCP_REG_RESET = 8'h00;
   localparam int SCP_CMD_BITS = 8;
   localparam int SCP_FRAME_BITS = 16;
   localparam int SCP_CLK_NS = 25;
   localparam int SCP_SCK_MAX_KHZ = 1000;
   localparam int SCP_GAP_NS = 300;
   // half period of the generated serial clock, rounded up so rate stays under max
   localparam int SCP_HALF_CYC = (1000000 / SCP_SCK_MAX_KHZ / 2 + SCP_CLK_NS - 1) / SCP_CLK_NS;
   localparam int SCP_GAP_CYC = (SCP_GAP_NS + SCP_CLK_NS - 1) / SCP_CLK_NS;
   typedef enum logic [1:0] {
      SCP_H_IDLE = 2'b00,
      SCP_H_SHIFT = 2'b01,
      SCP_H_GAP = 2'b10
   } scp_hstate_t;
endpackage

// file: src/scp_sync.sv
`timescale 1ns/1ps
module scp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   // two stages; only the second is read outside
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// file: tb/scp_props.sv
`timescale 1ns/1ps
module scp_props (
   input wire logic clk,
   input wire logic nrst,
   input wire logic protocol_select,
   input wire logic shared_serial_clock_pin,
   input wire logic shared_latch_or_datain_pin,
   input wire logic shared_dataout_pin,
   input wire logic dataout_oe
);
   logic [15:0] lo_r;
   logic [15:0] hi_r;
   wire logic sck = shared_serial_clock_pin;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // phase lengths of the serial clock; high count saturates over long idle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lo_r <= 16'h0000;
         hi_r <= 16'h0000;
      end else begin
         lo_r <= sck ? 16'h0000 : lo_r + 16'h0001;
         hi_r <= sck ? hi_r + {15'h0000, ~&hi_r} : 16'h0000;
      end
   end
   AST_SILENT_SEL_HIGH: assert property (protocol_select |-> !dataout_oe)
      else $error("data out driven while select high");
   AST_IDLE_HIGH: assert property (protocol_select |-> sck && shared_latch_or_datain_pin)
      else $error("clock or data in low while idle");
   AST_SEL_RISE_CLK: assert property ($rose(protocol_select) |-> sck && $past(sck))
      else $error("select rose with clock low");
   AST_SEL_FALL_CLK: assert property ($fell(protocol_select) |-> sck && $past(sck))
      else $error("select fell with clock low");
   AST_DOUT_ON_FALL: assert property ($changed(shared_dataout_pin) && dataout_oe
      && $past(dataout_oe) |-> !sck)
      else $error("data out changed while clock high");
   AST_OE_AFTER_FALL: assert property ($rose(dataout_oe) |-> !sck && !protocol_select)
      else $error("data out enabled outside clock low phase");
   AST_READ_WINDOW: assert property ($rose(dataout_oe) |-> dataout_oe [*8] ##[1:700] !dataout_oe)
      else $error("read data window of wrong length");
   AST_CLK_RATE: assert property ($rose(sck) |-> lo_r >= 16'h0014 && lo_r < 16'h0FA0)
      else $error("serial clock low phase out of range");
   AST_GAP_HIGH: assert property ($fell(sck) |-> hi_r >= 16'h000C)
      else $error("serial clock high time too short");
   // main scenarios seen on the wire
   cover property ($rose(dataout_oe));
   cover property ($fell(protocol_select));
   cover property ($fell(sck) && hi_r > 16'h0100);
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import scp_pkg::*;;
   logic clk, nrst, boot_lo, req, req_write, cfg_mode, busy, done, unlocked;
   logic [5:0] req_addr;
   logic [7:0] req_data, rd_data, burn_pulse_count;
   int err_count, checked;
   wire logic dev_sck;
   localparam logic [5:0] BA [5] = '{SCP_ADDR_BURN_RSV, SCP_ADDR_BURN_ZERO, SCP_ADDR_BURN_CFG,
      SCP_ADDR_BURN_SUPPLY, SCP_ADDR_BURN_CAL};
   localparam logic [7:0] BK [5] = '{SCP_KEY_RSV, SCP_KEY_ZERO, SCP_KEY_CFG, SCP_KEY_SUPPLY,
      SCP_KEY_CAL};
   scp_if scp_if_i();
   // gate lets the bench give the device its one boot edge with select high
   assign dev_sck = scp_if_i.shared_serial_clock_pin & ~boot_lo;
   scp_host scp_host_i (.clk(clk), .nrst(nrst), .link(scp_if_i.host), .req(req),
      .req_write(req_write), .req_addr(req_addr), .req_data(req_data), .cfg_mode(cfg_mode),
      .busy(busy), .done(done), .rd_data(rd_data));
   scp_device scp_device_i (.sck(dev_sck), .nrst(nrst), .link(scp_if_i.dev),
      .burn_pulse_count(burn_pulse_count), .unlocked(unlocked), .reg_image());
   scp_props scp_props_i (.clk(clk), .nrst(nrst), .protocol_select(scp_if_i.protocol_select),
      .shared_serial_clock_pin(scp_if_i.shared_serial_clock_pin),
      .shared_latch_or_datain_pin(scp_if_i.shared_latch_or_datain_pin),
      .shared_dataout_pin(scp_if_i.shared_dataout_pin), .dataout_oe(scp_if_i.dataout_oe));
   // free-running system clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask
   // one frame; bounded wait so a hung host counts as a mismatch
   task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req_write = w;
      req_addr = a;
      req_data = d;
      req = 1'b1;
      @(posedge clk) #1 req = 1'b0;
      while (done !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("done", 8'h01, {7'h00, done});
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
      xfer(1'b0, a, 8'h00);
      chk("rd_data", exp, rd_data);
   endtask
   task automatic boot();
      nrst = 1'b0;
      cfg_mode = 1'b0;
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (2) @(posedge clk);
      #1 boot_lo = 1'b1;
      repeat (2) @(posedge clk);
      #1 boot_lo = 1'b0;
      repeat (2) @(posedge clk);
      #1 cfg_mode = 1'b1;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic t_rw();
      xfer(1'b1, 6'h02, 8'h5A);
      rd_chk(6'h02, 8'h5A);
      xfer(1'b1, 6'h03, 8'hA5);
      rd_chk(6'h03, 8'hA5);
      $display("test rw done");
   endtask
   task automatic t_lock();
      xfer(1'b1, SCP_ADDR_UNLOCK, SCP_KEY_UNLOCK);
      chk("unlocked", 8'h01, {7'h00, unlocked});
      xfer(1'b1, 6'h05, 8'h33);
      rd_chk(6'h05, 8'h33);
      xfer(1'b1, SCP_ADDR_UNLOCK, 8'h00);
      chk("unlocked", 8'h00, {7'h00, unlocked});
      xfer(1'b1, 6'h05, 8'hC3);
      rd_chk(6'h05, 8'h33);
      xfer(1'b1, SCP_ADDR_UNLOCK, SCP_KEY_UNLOCK);
      $display("test lock done");
   endtask
   task automatic t_burn();
      logic [7:0] c;
      for (int i = 0; i < 5; i++) begin
         c = burn_pulse_count;
         xfer(1'b1, BA[i], BK[i] ^ 8'hFF);
         chk("burn_pulse_count", c, burn_pulse_count);
         xfer(1'b1, BA[i], BK[i]);
         chk("burn_pulse_count", c + 8'h01, burn_pulse_count);
      end
      $display("test burn done");
   endtask
   task automatic t_reload();
      boot();
      chk("unlocked", 8'h00, {7'h00, unlocked});
      rd_chk(6'h02, 8'h5A);
      rd_chk(6'h05, 8'h33);
      $display("test reload done");
   endtask
   task automatic t_refuse();
      cfg_mode = 1'b0;
      repeat (3) @(posedge clk);
      #1 req = 1'b1;
      repeat (3) @(posedge clk);
      #1 req = 1'b0;
      chk("busy", 8'h00, {7'h00, busy});
      chk("protocol_select", 8'h01, {7'h00, scp_if_i.protocol_select});
      $display("test refuse done");
   endtask
   task automatic report_and_stop();
      $display("counts: checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      err_count = 0;
      checked = 0;
      boot_lo = 1'b0;
      req = 1'b0;
      req_write = 1'b0;
      req_addr = 6'h00;
      req_data = 8'h00;
      boot();
      t_rw();
      t_lock();
      t_burn();
      t_reload();
      t_refuse();
      report_and_stop();
   end
   // about 25 frames of 700 cycles fit well inside this span
   initial begin
      #2000000;
      err_count++;
      $display("BAD watchdog exp finished got hung");
      report_and_stop();
   end
endmodule
